// >>> hdl/tcr_axil_slave.sv
`timescale 1ns/1ps
module tcr_axil_slave (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wrEn,
	output tcr_pkg::tcr_wr_t wr,
	output logic [7:0] rdAddr,
	input wire logic [31:0] rdData
);
	import tcr_pkg::*;
	typedef struct packed {
		logic awrdy;
		logic wrdy;
		logic arrdy;
		logic bvalid;
		logic rvalid;
		logic wrEn;
		logic rdEn;
		logic [1:0] bresp;
		logic [1:0] rresp;
		logic [31:0] rdata;
		tcr_wr_t wr;
		logic [7:0] rdAddr;
	} tcr_axs_t;
	localparam tcr_axs_t RST = '{awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1, default: '0};
	tcr_axs_t r;
	tcr_axs_t next_r;

	// address and data taken in either order, one write and one read in flight
	always_comb begin
		next_r = r;
		next_r.wrEn = 1'b0;
		next_r.rdEn = 1'b0;
		if (s_axi_awvalid && r.awrdy) begin
			next_r.wr.addr = s_axi_awaddr;
			next_r.awrdy = 1'b0;
		end
		if (s_axi_wvalid && r.wrdy) begin
			next_r.wr.data = s_axi_wdata;
			next_r.wr.strb = s_axi_wstrb;
			next_r.wrdy = 1'b0;
		end
		if (!r.awrdy && !r.wrdy && !r.bvalid) begin
			next_r.wrEn = 1'b1;
			next_r.bvalid = 1'b1;
			next_r.bresp = tcr_hit(r.wr.addr) ? `TCR_RESP_OKAY : `TCR_RESP_DECERR;
			next_r.awrdy = 1'b1;
			next_r.wrdy = 1'b1;
		end
		if (r.bvalid && s_axi_bready) next_r.bvalid = 1'b0;
		if (s_axi_arvalid && r.arrdy) begin
			next_r.rdAddr = s_axi_araddr;
			next_r.arrdy = 1'b0;
			next_r.rdEn = 1'b1;
		end
		if (r.rdEn) begin
			next_r.rvalid = 1'b1;
			next_r.rdata = rdData;
			next_r.rresp = tcr_hit(r.rdAddr) ? `TCR_RESP_OKAY : `TCR_RESP_DECERR;
		end
		if (r.rvalid && s_axi_rready) begin
			next_r.rvalid = 1'b0;
			next_r.arrdy = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) r <= RST;
		else if (clkEn) r <= next_r;
	end

	assign s_axi_awready = r.awrdy;
	assign s_axi_wready = r.wrdy;
	assign s_axi_arready = r.arrdy;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rdata = r.rdata;
	assign wrEn = r.wrEn;
	assign wr = r.wr;
	assign rdAddr = r.rdAddr;
endmodule : tcr_axil_slave

// >>> hdl/tcr_defs.svh
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH
// clock and machine cycle timing
`define TCR_CLK_NS 50
`define TCR_MC_NS 300
`define TCR_MC_CYC (`TCR_MC_NS / `TCR_CLK_NS)
// register byte offsets
`define TCR_OFS_CTRL 8'h00
`define TCR_OFS_CHCFG 8'h04
`define TCR_OFS_STAT 8'h08
`define TCR_OFS_COUNT 8'h0c
`define TCR_OFS_CC0 8'h10
`define TCR_OFS_CC1 8'h14
`define TCR_OFS_CC2 8'h18
`define TCR_OFS_CC3 8'h1c
`define TCR_OFS_PORT 8'h20
// control register field positions
`define TCR_CTRL_RUN 0
`define TCR_CTRL_DIV12 2
`define TCR_CTRL_RLD 3
`define TCR_CTRL_EXTEN 5
`define TCR_CTRL_EDGE 6
`define TCR_CTRL_SWCAP 7
// status register field positions
`define TCR_ST_OVF 0
`define TCR_ST_EXT 1
`define TCR_ST_CH 2
// port register: read-back of the outputs
`define TCR_PORT_OUT 4
// reset values and the counter maximum
`define TCR_CTRL_RST 8'h00
`define TCR_CHCFG_RST 8'h00
`define TCR_COUNT_RST 16'h0000
`define TCR_CC_RST 16'h0000
`define TCR_PORT_RST 4'h0
`define TCR_CNT_MAX 16'hffff
// bus responses
`define TCR_RESP_OKAY 2'h0
`define TCR_RESP_DECERR 2'h3
`endif

// >>> hdl/tcr_pin_sync.sv
`timescale 1ns/1ps
module tcr_pin_sync #(
	parameter int N = 6
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic tick,
	input wire logic [N-1:0] pins,
	output logic [N-1:0] level,
	output logic [N-1:0] rise,
	output logic [N-1:0] fall
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] smp;
		logic [N-1:0] rise;
		logic [N-1:0] fall;
		logic primed;
	} tcr_sync_t;
	tcr_sync_t r;
	tcr_sync_t next_r;

	// two-flop synchroniser, then one sample per machine cycle
	always_comb begin
		next_r = r;
		next_r.s1 = pins;
		next_r.s2 = r.s1;
		next_r.rise = '0;
		next_r.fall = '0;
		if (tick) begin
			next_r.smp = r.s2;
			next_r.primed = 1'b1;
			if (r.primed) begin
				next_r.rise = r.s2 & ~r.smp;
				next_r.fall = r.smp & ~r.s2;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) r <= '0;
		else if (clkEn) r <= next_r;
	end

	assign level = r.smp;
	assign rise = r.rise;
	assign fall = r.fall;
endmodule : tcr_pin_sync

// >>> hdl/tcr_pkg.sv
package tcr_pkg;
`include "tcr_defs.svh"
	// counter source selection
	typedef enum logic [1:0] {RUN_STOP, RUN_TIMER, RUN_GATED, RUN_EVENT} tcr_run_t;
	// reload source selection, last code unused
	typedef enum logic [1:0] {RLD_NONE, RLD_OVF, RLD_PIN} tcr_rld_t;
	// per-channel function
	typedef enum logic [1:0] {CH_OFF, CH_CMP0, CH_CMP1, CH_CAP} tcr_chfn_t;
	// one register write as handed from the bus slave
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} tcr_wr_t;

	// word-aligned address inside the map
	function automatic logic tcr_hit(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= `TCR_OFS_PORT);
	endfunction : tcr_hit

	// apply byte enables to an old register value
	function automatic logic [31:0] tcr_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] v;
		v = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) v[8*b +: 8] = d[8*b +: 8];
		end
		return v;
	endfunction : tcr_merge
endpackage : tcr_pkg

// >>> hdl/tcr_timer_capture_compare.sv
// How it works
// - 16-bit counter wrap sets overflow flag
// - timer rate is osc/6 or osc/12
// - gated mode counts only while gate high
// - gate pin sampled once per machine cycle
// - event mode counts gate pin falling edges
// - reload mode 0 reloads counter on wrap
// - reload mode 1 reloads on pin fall
// - reload pin fall sets event flag if enabled
// - channel match drives pin, sets request
// - compare mode 0: high on match, low on wrap
// - compare mode 0 ignores software port writes
// - compare mode 1 copies shadow on match
// - all four registers can capture counter
// - channels 1-3 capture on rising pin edge
// - reload register edge chosen by select bit
// - low-byte write captures one cycle later
// - software capture raises no request
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "tcr_defs.svh"
module tcr_timer_capture_compare (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic gateEventPin,
	input wire logic reloadPin,
	input wire logic [3:0] ccPin,
	output logic [3:0] cmpOut
);
	import tcr_pkg::*;

	localparam int MC_W = $clog2(`TCR_MC_CYC);
	localparam logic [MC_W-1:0] MC_LAST = MC_W'(`TCR_MC_CYC - 1);
	localparam int NCH = 4;
	// pin bundle positions
	localparam int P_GATE = 0;
	localparam int P_RLD = 1;
	localparam int P_CC = 2;

	typedef struct packed {
		logic [MC_W-1:0] mc;
		logic half;
		logic [7:0] ctrl;
		logic [7:0] chCfg;
		logic ovf;
		logic ext;
		logic [NCH-1:0] chFlag;
		logic [15:0] count;
		logic [NCH-1:0][15:0] cc;
		logic [NCH-1:0] shadow;
		logic [NCH-1:0] cmpOut;
		logic [NCH-1:0] swCap;
	} tcr_state_t;

	localparam tcr_state_t RST = '{
		ctrl: `TCR_CTRL_RST,
		chCfg: `TCR_CHCFG_RST,
		count: `TCR_COUNT_RST,
		cc: {NCH{`TCR_CC_RST}},
		shadow: `TCR_PORT_RST,
		cmpOut: `TCR_PORT_RST,
		default: '0
	};

	tcr_state_t r;
	tcr_state_t next_r;
	logic wrEn;
	tcr_wr_t wr;
	logic [7:0] rdAddr;
	logic [31:0] rdData;
	logic [5:0] pinLvl;
	logic [5:0] pinRise;
	logic [5:0] pinFall;
	logic mcTick;
	logic pscTick;
	logic step;
	logic ovfNow;
	logic [15:0] stepVal;
	logic [31:0] wv;
	logic [5:0] clr;
	logic [NCH-1:0] capEv;
	logic [NCH-1:0] match;
	tcr_run_t run;
	tcr_rld_t rld;

	// channel function from the configuration register
	function automatic tcr_chfn_t chFn(input int i);
		return tcr_chfn_t'(r.chCfg[2*i +: 2]);
	endfunction : chFn

	// register read view, shared by the read path and byte-merged writes
	function automatic logic [31:0] regRead(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0;
		case (a)
			`TCR_OFS_CTRL: v = {24'h0, r.ctrl};
			`TCR_OFS_CHCFG: v = {24'h0, r.chCfg};
			`TCR_OFS_STAT: v = {26'h0, r.chFlag, r.ext, r.ovf};
			`TCR_OFS_COUNT: v = {16'h0, r.count};
			`TCR_OFS_CC0, `TCR_OFS_CC1, `TCR_OFS_CC2, `TCR_OFS_CC3: v = {16'h0, r.cc[a[3:2]]};
			`TCR_OFS_PORT: v = {24'h0, r.cmpOut, r.shadow};
			default: v = 32'h0;
		endcase
		return v;
	endfunction : regRead

	tcr_axil_slave u_bus (
		.core_clk(core_clk),
		.resetn(resetn),
		.clkEn(clkEn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wrEn(wrEn),
		.wr(wr),
		.rdAddr(rdAddr),
		.rdData(rdData)
	);

	// external pins enter through the synchroniser, sampled per machine cycle
	tcr_pin_sync #(.N(6)) u_pins (
		.core_clk(core_clk),
		.resetn(resetn),
		.clkEn(clkEn),
		.tick(mcTick),
		.pins({ccPin, reloadPin, gateEventPin}),
		.level(pinLvl),
		.rise(pinRise),
		.fall(pinFall)
	);

	assign rdData = regRead(rdAddr);
	assign run = tcr_run_t'(r.ctrl[`TCR_CTRL_RUN +: 2]);
	assign rld = tcr_rld_t'(r.ctrl[`TCR_CTRL_RLD +: 2]);
	assign mcTick = (r.mc == MC_LAST);
	// every machine cycle, or every second one when dividing by twelve
	assign pscTick = mcTick && (!r.ctrl[`TCR_CTRL_DIV12] || r.half);
	assign ovfNow = step && (r.count == `TCR_CNT_MAX);
	assign wv = tcr_merge(regRead(wr.addr), wr.data, wr.strb);
	assign clr = (wrEn && wr.addr == `TCR_OFS_STAT && wr.strb[0]) ? wr.data[5:0] : 6'h0;

	// count source selection
	always_comb begin
		unique case (run)
			RUN_STOP: step = 1'b0;
			RUN_TIMER: step = pscTick;
			RUN_GATED: step = pscTick && pinLvl[P_GATE];
			RUN_EVENT: step = pinFall[P_GATE];
		endcase
	end

	// value taken on a step: reload value on wrap in reload mode 0
	always_comb begin
		if (ovfNow && rld == RLD_OVF) stepVal = r.cc[0];
		else stepVal = r.count + 16'h0001;
	end

	// per-channel compare hits and pin capture events
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			match[i] = step && (stepVal == r.cc[i]);
			if (i == 0) capEv[i] = r.ctrl[`TCR_CTRL_EDGE] ? pinRise[P_CC] : pinFall[P_CC];
			else capEv[i] = pinRise[P_CC + i];
		end
	end

	// next state of the whole block
	always_comb begin
		next_r = r;
		next_r.mc = mcTick ? '0 : r.mc + MC_W'(1);
		if (mcTick) next_r.half = ~r.half;
		// pending software captures land one cycle after the write
		for (int i = 0; i < NCH; i++) begin
			if (r.swCap[i]) begin
				next_r.cc[i] = r.count;
				next_r.swCap[i] = 1'b0;
			end
		end
		// register writes
		if (wrEn) begin
			case (wr.addr)
				`TCR_OFS_CTRL: next_r.ctrl = wv[7:0];
				`TCR_OFS_CHCFG: next_r.chCfg = wv[7:0];
				`TCR_OFS_CC0, `TCR_OFS_CC1, `TCR_OFS_CC2, `TCR_OFS_CC3: begin
					next_r.cc[wr.addr[3:2]] = wv[15:0];
					if (wr.strb[0] && r.ctrl[`TCR_CTRL_SWCAP] && chFn(int'(wr.addr[3:2])) == CH_CAP) begin
						next_r.swCap[wr.addr[3:2]] = 1'b1;
					end
				end
				`TCR_OFS_PORT: next_r.shadow = wv[3:0];
				default: ;
			endcase
		end
		// write-one-to-clear first, so a same-cycle set wins
		next_r.ovf = r.ovf & ~clr[`TCR_ST_OVF];
		next_r.ext = r.ext & ~clr[`TCR_ST_EXT];
		next_r.chFlag = r.chFlag & ~clr[`TCR_ST_CH +: NCH];
		// counter advance and overflow
		if (step) next_r.count = stepVal;
		if (ovfNow) next_r.ovf = 1'b1;
		// falling edge on the reload pin
		if (pinFall[P_RLD]) begin
			if (rld == RLD_PIN) next_r.count = r.cc[0];
			if (r.ctrl[`TCR_CTRL_EXTEN]) next_r.ext = 1'b1;
		end
		// channels
		for (int i = 0; i < NCH; i++) begin
			unique case (chFn(i))
				CH_OFF: next_r.cmpOut[i] = next_r.shadow[i];
				CH_CMP0: begin
					// port writes never reach the output here
					if (ovfNow) next_r.cmpOut[i] = 1'b0;
					if (match[i]) begin
						next_r.cmpOut[i] = 1'b1;
						next_r.chFlag[i] = 1'b1;
					end
				end
				CH_CMP1: begin
					if (match[i]) begin
						next_r.cmpOut[i] = r.shadow[i];
						next_r.chFlag[i] = 1'b1;
					end
				end
				CH_CAP: begin
					if (!r.ctrl[`TCR_CTRL_SWCAP] && capEv[i]) begin
						next_r.cc[i] = r.count;
						next_r.chFlag[i] = 1'b1;
					end
				end
			endcase
		end
		// software load of the counter overrides hardware
		if (wrEn && wr.addr == `TCR_OFS_COUNT) next_r.count = wv[15:0];
	end

	// all block state in one register, frozen while the clock enable is low
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) r <= RST;
		else if (clkEn) r <= next_r;
	end

	assign cmpOut = r.cmpOut;
endmodule : tcr_timer_capture_compare

// >>> verification/tcr_chk.sv
`timescale 1ns/1ps
module tcr_chk (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] cmpOut
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	// register reads: answer time, refusal while busy, one beat, unmapped code
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
	property p_r_once;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_once: assert property (p_r_once) else $error("read answered twice");
	property p_decerr;
		s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h20) |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0);
	endproperty
	a_decerr: assert property (p_decerr) else $error("unmapped read wrong");
	// register writes: answer two edges after, ready returns with the response
	property p_wr_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
	property p_b_once;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_once: assert property (p_b_once) else $error("write answered twice");
	property p_rdy_back;
		s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready;
	endproperty
	a_rdy_back: assert property (p_rdy_back) else $error("write ready not back");
	// outputs low once reset ends
	property p_cmp_reset;
		$rose(resetn) |-> cmpOut == 4'h0;
	endproperty
	a_cmp_reset: assert property (p_cmp_reset) else $error("outputs high after reset");
endmodule : tcr_chk
bind tcr_timer_capture_compare tcr_chk u_tcr_chk (.core_clk, .resetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmpOut);

// >>> verification/tcr_pin_model.sv
`timescale 1ns/1ps
module tcr_pin_model (
	input wire logic core_clk,
	output logic gateEventPin,
	output logic reloadPin,
	output logic [3:0] ccPin
);
	// idle: gate and reload pulled high, capture inputs low
	logic [5:0] lvl = 6'h30;
	assign {gateEventPin, reloadPin, ccPin} = lvl;
	// change one pin after an edge, then hold it two machine cycles
	task automatic pin(input int idx, input logic v);
		@(posedge core_clk);
		lvl[idx] <= v;
		repeat (12) @(posedge core_clk);
	endtask : pin
endmodule : tcr_pin_model

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic clkEn = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, gateEventPin, reloadPin, seen;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, d;
	logic [3:0] ccPin, cmpOut;
	int failures = 0, compares = 0;
	// clock
	always #25 core_clk = ~core_clk;
	tcr_timer_capture_compare u_tcr_timer_capture_compare (.core_clk, .resetn, .clkEn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .gateEventPin, .reloadPin, .ccPin, .cmpOut);
	tcr_pin_model u_pins (.core_clk, .gateEventPin, .reloadPin, .ccPin);
	// compare and count
	task automatic check(input string w, input logic [31:0] seenV, input logic [31:0] exp);
		compares++;
		if (seenV !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", w, exp, seenV);
		end
	endtask : check
	// bus write, both channels offered together, then two idle edges
	task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask : axw
	// bus read into d and r
	task automatic axr(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : axr
	task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e);
		axr(a);
		check(w, d, e);
		check(w, r, 2'h0);
	endtask : rchk
	task automatic t_reset;
		rchk("ctrl", 8'h00, 32'h0);
		rchk("count", 8'h0c, 32'h0);
		rchk("port", 8'h20, 32'h0);
		axr(8'h24);
		check("unmapped", {30'h0, r}, 32'h3);
		$display("test reset done");
	endtask : t_reset
	// run a while, stop, count steps
	task automatic t_rate(input logic [7:0] ctl, input int lo);
		axw(8'h0c, 32'h0);
		axw(8'h00, {24'h0, ctl});
		repeat (120) @(posedge core_clk);
		axw(8'h00, 32'h0);
		axr(8'h0c);
		check("rate", (d >= lo) && (d <= lo + 1), 32'h1);
		$display("test rate done");
	endtask : t_rate
	// clock enable low freezes the running counter
	task automatic t_freeze;
		axw(8'h0c, 32'h0);
		axw(8'h00, 32'h01);
		clkEn <= 1'b0;
		repeat (120) @(posedge core_clk);
		clkEn <= 1'b1;
		axw(8'h00, 32'h0);
		axr(8'h0c);
		check("frozen", d <= 2, 32'h1);
		$display("test freeze done");
	endtask : t_freeze
	task automatic t_overflow;
		axw(8'h10, 32'hfff0);
		axw(8'h14, 32'hfffe);
		axw(8'h04, 32'h04);
		axw(8'h0c, 32'hfffc);
		axw(8'h00, 32'h09);
		seen = 1'b0;
		repeat (40) begin
			@(posedge core_clk);
			seen |= cmpOut[1];
		end
		axw(8'h00, 32'h0);
		check("match high", seen, 32'h1);
		check("wrap low", cmpOut[1], 32'h0);
		axr(8'h0c);
		check("reloaded", d & 32'hfff0, 32'hfff0);
		axr(8'h08);
		check("flags", d & 32'h0b, 32'h09);
		axw(8'h08, 32'h3f);
		rchk("cleared", 8'h08, 32'h0);
		$display("test overflow done");
	endtask : t_overflow
	task automatic t_cmp;
		axw(8'h18, 32'h5);
		axw(8'h1c, 32'h5);
		axw(8'h04, 32'h60);
		axw(8'h0c, 32'h0);
		axw(8'h20, 32'h0c);
		check("before match", cmpOut, 32'h0);
		axw(8'h00, 32'h01);
		repeat (60) @(posedge core_clk);
		axw(8'h00, 32'h0);
		check("after match", cmpOut, 32'hc);
		axw(8'h20, 32'h0);
		check("shadow held", cmpOut, 32'hc);
		$display("test compare done");
	endtask : t_cmp
	task automatic t_event;
		axw(8'h0c, 32'h0);
		axw(8'h00, 32'h03);
		repeat (5) begin
			u_pins.pin(5, 1'b0);
			u_pins.pin(5, 1'b1);
		end
		rchk("events", 8'h0c, 32'h5);
		axw(8'h00, 32'h0);
		u_pins.pin(5, 1'b0);
		axw(8'h00, 32'h02);
		repeat (60) @(posedge core_clk);
		rchk("gate low", 8'h0c, 32'h5);
		u_pins.pin(5, 1'b1);
		repeat (60) @(posedge core_clk);
		axw(8'h00, 32'h0);
		axr(8'h0c);
		check("gate high", d > 5, 32'h1);
		$display("test event done");
	endtask : t_event
	task automatic t_reload;
		axw(8'h10, 32'h1234);
		axw(8'h0c, 32'h0);
		axw(8'h08, 32'h3f);
		axw(8'h00, 32'h33);
		u_pins.pin(4, 1'b0);
		u_pins.pin(4, 1'b1);
		rchk("reload", 8'h0c, 32'h1234);
		rchk("ext flag", 8'h08, 32'h2);
		axw(8'h08, 32'h3f);
		axw(8'h00, 32'h13);
		u_pins.pin(4, 1'b0);
		u_pins.pin(4, 1'b1);
		rchk("ext off", 8'h08, 32'h0);
		$display("test reload done");
	endtask : t_reload
	task automatic t_capture;
		axw(8'h04, 32'hff);
		axw(8'h0c, 32'h42);
		u_pins.pin(1, 1'b1);
		rchk("cap ch1", 8'h14, 32'h42);
		u_pins.pin(0, 1'b1);
		rchk("no cap rise", 8'h10, 32'h1234);
		axw(8'h0c, 32'h77);
		u_pins.pin(0, 1'b0);
		rchk("cap fall", 8'h10, 32'h77);
		rchk("cap flags", 8'h08, 32'h0c);
		axw(8'h08, 32'h3f);
		axw(8'h00, 32'h80);
		axw(8'h0c, 32'h99);
		axw(8'h18, 32'h0, 4'h1);
		rchk("sw cap", 8'h18, 32'h99);
		rchk("no flag", 8'h08, 32'h0);
		$display("test capture done");
	endtask : t_capture
	task automatic give_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict
	// main sequence
	initial begin
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset();
		t_rate(8'h01, 20);
		t_rate(8'h05, 10);
		t_freeze();
		t_overflow();
		t_cmp();
		t_event();
		t_reload();
		t_capture();
		give_verdict();
	end
	// watchdog
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		give_verdict();
	end
endmodule : testbench
